// >>> src/fpsc_defs.svh
`ifndef FPSC_DEFS_SVH
`define FPSC_DEFS_SVH

// Register byte addresses on the Wishbone bus
`define FPSC_ADDR_STATUS 8'h00
`define FPSC_ADDR_CONFIG 8'h04
`define FPSC_ADDR_PROT 8'h08
`define FPSC_ADDR_SEC 8'h0c
`define FPSC_ADDR_CMD 8'h10
`define FPSC_ADDR_KEY01 8'h14
`define FPSC_ADDR_KEY23 8'h18
`define FPSC_ADDR_DEBUG 8'h1c

// Configuration field byte addresses inside the flash array
`define FPSC_CFG_KEY_BASE 16'hff70
`define FPSC_CFG_PROT 16'hff7c
`define FPSC_CFG_NVOPT 16'hff7e
`define FPSC_CFG_SEC 16'hff7f

// Protection register fields
`define FPSC_PROT_OPEN_BIT 7
`define FPSC_PROT_HDIS_BIT 5
`define FPSC_PROT_HS_LSB 3

// Status register fields
`define FPSC_STAT_CMD_COMPLETE_FLAG_BIT 7
`define FPSC_STAT_PVIOL_BIT 4
`define FPSC_STAT_KEYOK_BIT 1
`define FPSC_STAT_KEYLOCK_BIT 0

// Security field encodings
`define FPSC_SEC_UNSECURE 2'b10
`define FPSC_BACKDOOR_KEY_ENABLE_ENABLED 2'b10

// Command codes
`define FPSC_CMD_ERASE_ALL 8'h08
`define FPSC_CMD_ERASE_BLOCK 8'h09
`define FPSC_CMD_PROGRAM 8'h06
`define FPSC_CMD_ERASE_SECTOR 8'h0a
`define FPSC_CMD_UNSECURE 8'h0b
`define FPSC_CMD_VERIFY_KEY 8'h0c

// Timing: key compare duration and command run length, in cycles
`define FPSC_KEY_CYCLES 4'd8
`define FPSC_CMD_CYCLES 4'd4

`endif

// >>> src/fpsc_pkg.sv
`default_nettype none
package fpsc_pkg;
  typedef struct packed {
    logic open_bit;
    logic hdis_bit;
    logic [1:0] size;
  } fpsc_prot_t;

  typedef struct packed {
    logic [7:0] cmd;
    logic [15:0] addr;
  } fpsc_cmd_t;

  typedef enum logic [2:0] {
    FPSC_BOOT_PROT = 3'b000,
    FPSC_BOOT_SEC = 3'b001,
    FPSC_BOOT_KEY = 3'b010,
    FPSC_IDLE = 3'b011,
    FPSC_KEYCHK = 3'b100,
    FPSC_EXEC = 3'b101,
    FPSC_ERVERIFY = 3'b110
  } fpsc_state_t;
endpackage
`default_nettype wire

// >>> src/fpsc_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "fpsc_defs.svh"

// Contract
// - Command interrupt asserts only when complete flag and enable are both set.
// - Complete flag clears while a command runs and sets when it finishes.
// - Two protectable regions: top-down higher region and all other flash.
// - Config field holds eight key bytes, protection, option and security bytes.
// - Protection register loads from the protection byte during reset sequence.
// - Open and higher-disable bits decode none, high, full or unprotected-high.
// - Software may rewrite protection after reset within allowed transitions.
// - Disallowed protection writes are ignored; register shows scenario in force.
// - Allowed: 1 to 1,3; 3 to 3; 5 to 3,5; 7 to any.
// - Size field selects 2, 4, 8 or 16 KB top range.
// - Security register loads from the security byte during reset sequence.
// - Newly programmed security byte takes effect only after next reset.
// - With keys enabled, four 16-bit keys compared; full match unsecures.
// - All-zero or all-ones key words never match.
// - During key verification flash reads are unavailable and return invalid data.
// - Successful key match forces security field to unsecure encoding 10.
// - After a failed compare, further key verifications refused until reset.
// - Key verification leaves stored security, keys and protection unchanged.
// - Erase-all or unsecure with verified-blank flash unsecures the device.
// - After unsecure by erase all debug commands become enabled.
module fpsc_top (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [15:0] cfg_addr,
  input wire logic [7:0] cfg_data,
  input wire logic flash_blank,
  output logic flash_read_block,
  output logic flash_erase_go,
  output logic flash_write_go,
  output logic [15:0] flash_op_addr,
  output logic debug_full_enable,
  output logic cmd_irq
);
  fpsc_pkg::fpsc_state_t state_reg;
  fpsc_pkg::fpsc_prot_t prot_reg;
  fpsc_pkg::fpsc_prot_t prot_wr;
  fpsc_pkg::fpsc_cmd_t cmd_reg;
  logic [7:0] sec_reg;
  logic [15:0] key_reg [4];
  logic [15:0] try_reg [4];
  logic [2:0] boot_idx_reg;
  logic [3:0] cnt_reg;
  logic cmd_complete_flag;
  logic cmd_complete_irq_en;
  logic pviol_reg;
  logic key_locked_reg;
  logic key_ok_reg;
  logic wb_hit;
  logic wr_cmd_launch;
  logic [3:0] key_match;
  logic [15:0] hi_base;
  logic in_high;
  logic protected_hit;
  logic [1:0] scen_cur;
  logic [1:0] scen_new;
  logic trans_ok;
  logic is_mod_cmd;

  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign prot_wr = '{open_bit: wb_dat_i[`FPSC_PROT_OPEN_BIT],
                     hdis_bit: wb_dat_i[`FPSC_PROT_HDIS_BIT],
                     size: wb_dat_i[`FPSC_PROT_HS_LSB +: 2]};
  assign wr_cmd_launch = wb_hit && wb_we_i && wb_sel_i[0] && wb_adr_i == `FPSC_ADDR_STATUS
    && wb_dat_i[`FPSC_STAT_CMD_COMPLETE_FLAG_BIT] && cmd_complete_flag;

  // Scenario index: open/hdis pairs 11,10,01,00 map to 7,5,3,1 as 2'b11..2'b00
  assign scen_cur = {prot_reg.open_bit, prot_reg.hdis_bit};
  assign scen_new = {prot_wr.open_bit, prot_wr.hdis_bit};
  always_comb begin
    case (scen_cur)
      2'b11: trans_ok = 1'b1;
      2'b10: trans_ok = (scen_new == 2'b10) || (scen_new == 2'b01);
      2'b01: trans_ok = (scen_new == 2'b01);
      2'b00: trans_ok = (scen_new == 2'b00) || (scen_new == 2'b01);
      default: trans_ok = 1'b0;
    endcase
    // Higher range may not shrink while scenario 5 or 3 is kept
    if (scen_new[1] != scen_new[0] && scen_new == scen_cur && prot_wr.size < prot_reg.size)
      trans_ok = 1'b0;
  end

  // Higher region base: 2 KB shifted by the size field
  always_comb begin
    case (prot_reg.size)
      2'b00: hi_base = 16'hf800;
      2'b01: hi_base = 16'hf000;
      2'b10: hi_base = 16'he000;
      default: hi_base = 16'hc000;
    endcase
  end
  assign in_high = cmd_reg.addr >= hi_base;
  always_comb begin
    case (scen_cur)
      2'b11: protected_hit = 1'b0;
      2'b10: protected_hit = in_high;
      2'b01: protected_hit = 1'b1;
      2'b00: protected_hit = !in_high;
      default: protected_hit = 1'b1;
    endcase
    // Whole-array operations need every region open
    if (cmd_reg.cmd == `FPSC_CMD_ERASE_ALL || cmd_reg.cmd == `FPSC_CMD_ERASE_BLOCK
        || cmd_reg.cmd == `FPSC_CMD_UNSECURE)
      protected_hit = scen_cur != 2'b11;
  end
  assign is_mod_cmd = cmd_reg.cmd == `FPSC_CMD_PROGRAM || cmd_reg.cmd == `FPSC_CMD_ERASE_ALL
    || cmd_reg.cmd == `FPSC_CMD_ERASE_BLOCK || cmd_reg.cmd == `FPSC_CMD_ERASE_SECTOR
    || cmd_reg.cmd == `FPSC_CMD_UNSECURE;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_key
      assign key_match[gi] = key_reg[gi] == try_reg[gi]
        && key_reg[gi] != 16'h0000 && key_reg[gi] != 16'hffff;
    end
  endgenerate

  // Boot sequence and command engine
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= fpsc_pkg::FPSC_BOOT_PROT;
      boot_idx_reg <= 3'h0;
      cnt_reg <= 4'h0;
      cfg_addr <= `FPSC_CFG_PROT;
      prot_reg <= '0;
      sec_reg <= 8'h00;
      key_locked_reg <= 1'b0;
      key_ok_reg <= 1'b0;
      pviol_reg <= 1'b0;
      cmd_complete_flag <= 1'b0;
      flash_read_block <= 1'b0;
      flash_erase_go <= 1'b0;
      flash_write_go <= 1'b0;
      flash_op_addr <= 16'h0000;
      debug_full_enable <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        key_reg[i] <= 16'h0000;
      end
    end else begin
      flash_erase_go <= 1'b0;
      flash_write_go <= 1'b0;
      if (wb_hit && wb_we_i && wb_sel_i[0] && wb_adr_i == `FPSC_ADDR_STATUS
          && wb_dat_i[`FPSC_STAT_PVIOL_BIT])
        pviol_reg <= 1'b0;
      case (state_reg)
        fpsc_pkg::FPSC_BOOT_PROT: begin
          // Address presented one cycle ahead; data sampled now
          if (cnt_reg == 4'h1) begin
            prot_reg <= '{open_bit: cfg_data[`FPSC_PROT_OPEN_BIT],
                          hdis_bit: cfg_data[`FPSC_PROT_HDIS_BIT],
                          size: cfg_data[`FPSC_PROT_HS_LSB +: 2]};
            cfg_addr <= `FPSC_CFG_SEC;
            cnt_reg <= 4'h0;
            state_reg <= fpsc_pkg::FPSC_BOOT_SEC;
          end else begin
            cnt_reg <= cnt_reg + 4'h1;
          end
        end
        fpsc_pkg::FPSC_BOOT_SEC: begin
          if (cnt_reg == 4'h1) begin
            sec_reg <= cfg_data;
            cfg_addr <= `FPSC_CFG_KEY_BASE;
            cnt_reg <= 4'h0;
            state_reg <= fpsc_pkg::FPSC_BOOT_KEY;
          end else begin
            cnt_reg <= cnt_reg + 4'h1;
          end
        end
        fpsc_pkg::FPSC_BOOT_KEY: begin
          if (boot_idx_reg[0])
            key_reg[boot_idx_reg[2:1]][7:0] <= cfg_data;
          else
            key_reg[boot_idx_reg[2:1]][15:8] <= cfg_data;
          if (boot_idx_reg == 3'h7) begin
            cmd_complete_flag <= 1'b1;
            state_reg <= fpsc_pkg::FPSC_IDLE;
          end else begin
            cfg_addr <= `FPSC_CFG_KEY_BASE + {13'h0, boot_idx_reg + 3'h1};
          end
          boot_idx_reg <= boot_idx_reg + 3'h1;
        end
        fpsc_pkg::FPSC_IDLE: begin
          if (wr_cmd_launch) begin
            cmd_complete_flag <= 1'b0;
            cnt_reg <= 4'h0;
            if (cmd_reg.cmd == `FPSC_CMD_VERIFY_KEY) begin
              if (key_locked_reg || sec_reg[7:6] != `FPSC_BACKDOOR_KEY_ENABLE_ENABLED) begin
                state_reg <= fpsc_pkg::FPSC_EXEC;
              end else begin
                flash_read_block <= 1'b1;
                state_reg <= fpsc_pkg::FPSC_KEYCHK;
              end
            end else if (is_mod_cmd && protected_hit) begin
              pviol_reg <= 1'b1;
              state_reg <= fpsc_pkg::FPSC_EXEC;
            end else begin
              flash_op_addr <= cmd_reg.addr;
              // Codes without an array action must not pulse the erase strobe
              flash_erase_go <= is_mod_cmd && cmd_reg.cmd != `FPSC_CMD_PROGRAM;
              flash_write_go <= cmd_reg.cmd == `FPSC_CMD_PROGRAM;
              state_reg <= (cmd_reg.cmd == `FPSC_CMD_ERASE_ALL
                || cmd_reg.cmd == `FPSC_CMD_UNSECURE)
                ? fpsc_pkg::FPSC_ERVERIFY : fpsc_pkg::FPSC_EXEC;
            end
          end
        end
        fpsc_pkg::FPSC_KEYCHK: begin
          if (cnt_reg == `FPSC_KEY_CYCLES - 4'h1) begin
            flash_read_block <= 1'b0;
            cmd_complete_flag <= 1'b1;
            state_reg <= fpsc_pkg::FPSC_IDLE;
            if (&key_match) begin
              sec_reg[1:0] <= `FPSC_SEC_UNSECURE;
              key_ok_reg <= 1'b1;
            end else begin
              key_locked_reg <= 1'b1;
            end
          end
          cnt_reg <= cnt_reg + 4'h1;
        end
        fpsc_pkg::FPSC_ERVERIFY: begin
          if (cnt_reg == `FPSC_CMD_CYCLES - 4'h1) begin
            cmd_complete_flag <= 1'b1;
            state_reg <= fpsc_pkg::FPSC_IDLE;
            if (flash_blank) begin
              sec_reg[1:0] <= `FPSC_SEC_UNSECURE;
              debug_full_enable <= 1'b1;
            end
          end
          cnt_reg <= cnt_reg + 4'h1;
        end
        fpsc_pkg::FPSC_EXEC: begin
          if (cnt_reg == `FPSC_CMD_CYCLES - 4'h1) begin
            cmd_complete_flag <= 1'b1;
            state_reg <= fpsc_pkg::FPSC_IDLE;
          end
          cnt_reg <= cnt_reg + 4'h1;
        end
        default: state_reg <= fpsc_pkg::FPSC_IDLE;
      endcase
      // Software protection writes only once the boot load is done
      if (state_reg == fpsc_pkg::FPSC_IDLE && wb_hit && wb_we_i && wb_sel_i[0]
          && wb_adr_i == `FPSC_ADDR_PROT && trans_ok)
        prot_reg <= prot_wr;
    end
  end

  // Command parameters, locked while a command runs
  always_ff @(posedge clk) begin
    if (reset) begin
      cmd_reg <= '0;
      cmd_complete_irq_en <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        try_reg[i] <= 16'h0000;
      end
    end else if (wb_hit && wb_we_i) begin
      if (wb_adr_i == `FPSC_ADDR_CONFIG && wb_sel_i[0])
        cmd_complete_irq_en <= wb_dat_i[7];
      if (cmd_complete_flag) begin
        if (wb_adr_i == `FPSC_ADDR_CMD && wb_sel_i == 4'hf)
          cmd_reg <= wb_dat_i[23:0];
        if (wb_adr_i == `FPSC_ADDR_KEY01 && wb_sel_i == 4'hf) begin
          try_reg[0] <= wb_dat_i[31:16];
          try_reg[1] <= wb_dat_i[15:0];
        end
        if (wb_adr_i == `FPSC_ADDR_KEY23 && wb_sel_i == 4'hf) begin
          try_reg[2] <= wb_dat_i[31:16];
          try_reg[3] <= wb_dat_i[15:0];
        end
      end
    end
  end

  // Wishbone answer one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge clk) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_hit;
      wb_dat_o <= 32'h0000_0000;
      if (wb_hit && !wb_we_i) begin
        case (wb_adr_i)
          `FPSC_ADDR_STATUS: wb_dat_o <= {24'h0, cmd_complete_flag, 2'b00, pviol_reg,
                                          2'b00, key_ok_reg, key_locked_reg};
          `FPSC_ADDR_CONFIG: wb_dat_o <= {24'h0, cmd_complete_irq_en, 7'h00};
          `FPSC_ADDR_PROT: wb_dat_o <= {24'h0, prot_reg.open_bit, 1'b0, prot_reg.hdis_bit,
                                        prot_reg.size, 3'b000};
          `FPSC_ADDR_SEC: wb_dat_o <= {24'h0, sec_reg};
          `FPSC_ADDR_CMD: wb_dat_o <= {8'h00, cmd_reg};
          `FPSC_ADDR_DEBUG: wb_dat_o <= {31'h0, debug_full_enable};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Registered so the interrupt line is glitch-free
  always_ff @(posedge clk) begin
    if (reset)
      cmd_irq <= 1'b0;
    else
      cmd_irq <= cmd_complete_flag && cmd_complete_irq_en;
  end

  AST_IRQ_CAUSE: assert property (@(posedge clk) disable iff (reset)
    cmd_irq |-> $past(cmd_complete_flag) && $past(cmd_complete_irq_en))
    else $error("irq without cause");
  AST_IRQ_SET: assert property (@(posedge clk) disable iff (reset)
    cmd_complete_flag && cmd_complete_irq_en |=> cmd_irq)
    else $error("irq missing");
  AST_FLAG_CLEARS: assert property (@(posedge clk) disable iff (reset)
    wr_cmd_launch && state_reg == fpsc_pkg::FPSC_IDLE |=> !cmd_complete_flag)
    else $error("flag not cleared on launch");
  AST_FLAG_RETURNS: assert property (@(posedge clk) disable iff (reset)
    $fell(cmd_complete_flag) |-> ##[1:10] cmd_complete_flag)
    else $error("command never completed");
  AST_PROT_ILLEGAL: assert property (@(posedge clk) disable iff (reset)
    state_reg == fpsc_pkg::FPSC_IDLE && wb_hit && wb_we_i && wb_sel_i[0]
    && wb_adr_i == `FPSC_ADDR_PROT && !trans_ok |=> $stable(prot_reg))
    else $error("illegal protection change");
  AST_NO_UNPROTECT: assert property (@(posedge clk) disable iff (reset)
    $past(state_reg) == fpsc_pkg::FPSC_IDLE && $past(scen_cur) == 2'b01
    |-> scen_cur == 2'b01)
    else $error("full protection removed");
  AST_READ_BLOCK: assert property (@(posedge clk) disable iff (reset)
    state_reg == fpsc_pkg::FPSC_KEYCHK |-> flash_read_block)
    else $error("reads open during key check");
  AST_KEY_LOCK: assert property (@(posedge clk) disable iff (reset)
    key_locked_reg |-> state_reg != fpsc_pkg::FPSC_KEYCHK)
    else $error("key check after lock");
  AST_KEY_NOPROT: assert property (@(posedge clk) disable iff (reset)
    state_reg == fpsc_pkg::FPSC_KEYCHK |=> $stable(prot_reg) && $stable(key_reg[0]))
    else $error("key check changed state");
  AST_PVIOL: assert property (@(posedge clk) disable iff (reset)
    wr_cmd_launch && state_reg == fpsc_pkg::FPSC_IDLE && is_mod_cmd && protected_hit
    |=> pviol_reg && !flash_erase_go && !flash_write_go)
    else $error("protected region modified");
  AST_WRITE_SCOPE: assert property (@(posedge clk) disable iff (reset)
    flash_write_go |-> $past(cmd_reg.cmd) == `FPSC_CMD_PROGRAM && !$past(protected_hit))
    else $error("write strobe without program");
  AST_ERASE_SCOPE: assert property (@(posedge clk) disable iff (reset)
    flash_erase_go |-> $past(is_mod_cmd) && $past(cmd_reg.cmd) != `FPSC_CMD_PROGRAM
    && !$past(protected_hit))
    else $error("erase strobe without erase");
  AST_KEY_UNSEC: assert property (@(posedge clk) disable iff (reset)
    $rose(key_ok_reg) |-> sec_reg[1:0] == `FPSC_SEC_UNSECURE)
    else $error("key match left device secured");
  AST_ERASE_UNSEC: assert property (@(posedge clk) disable iff (reset)
    $rose(debug_full_enable) |-> sec_reg[1:0] == `FPSC_SEC_UNSECURE)
    else $error("erase unlock left device secured");
  AST_SEC_HOLD: assert property (@(posedge clk) disable iff (reset)
    $past(state_reg) != fpsc_pkg::FPSC_BOOT_SEC |-> $stable(sec_reg[7:2]))
    else $error("security byte changed outside boot");
  COV_KEY_OK: cover property (@(posedge clk) $rose(key_ok_reg));
  COV_KEY_LOCK: cover property (@(posedge clk) $rose(key_locked_reg));
  COV_ERASE_UNSEC: cover property (@(posedge clk) $rose(debug_full_enable));
  COV_PVIOL: cover property (@(posedge clk) $rose(pviol_reg));
  COV_PROT_REFUSED: cover property (@(posedge clk) state_reg == fpsc_pkg::FPSC_IDLE
    && wb_hit && wb_we_i && wb_adr_i == `FPSC_ADDR_PROT && !trans_ok);
endmodule // fpsc_top
`default_nettype wire

// >>> testbench/fpsc_flash_model.sv
`timescale 1ns/10ps
`default_nettype none
module fpsc_flash_model (
  input wire logic clk,
  input wire logic [15:0] cfg_addr,
  output logic [7:0] cfg_data,
  input wire logic erase_go,
  output logic blank
);
  // Config field: keys, reserved bytes as ff, protection, option, security
  logic [7:0] mem [16];
  logic [7:0] junk;
  initial begin
    mem = '{8'h12, 8'h34, 8'h56, 8'h78, 8'h9a, 8'hbc, 8'hde, 8'hf0,
      8'hff, 8'hff, 8'hff, 8'hff, 8'ha0, 8'hff, 8'hff, 8'h80};
    junk = 8'h5a;
    blank = 1'b0;
  end
  // Outside the field the data toggles, so a stale byte never looks right
  always @(posedge clk) junk <= ~junk;
  assign cfg_data = (cfg_addr[15:4] === 12'hff7) ? mem[cfg_addr[3:0]] : junk;
  // Array reads blank once an erase has been launched
  always @(posedge clk) if (erase_go === 1'b1) blank <= 1'b1;
endmodule // fpsc_flash_model
`default_nettype wire

// >>> testbench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "fpsc_defs.svh"
module tb_top;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic [15:0] cfg_addr;
  logic [7:0] cfg_data;
  logic blank;
  logic read_block;
  logic erase_go;
  logic write_go;
  logic dbg_en;
  logic irq;
  int checks = 0;
  int miscompares = 0;
  int wr_n = 0;
  int er_n = 0;
  logic [7:0] pw [6] = '{8'h88, 8'ha0, 8'h00, 8'h38, 8'h18, 8'hb8};
  logic [7:0] pe [6] = '{8'h98, 8'h98, 8'h98, 8'h38, 8'h38, 8'h38};

  always #5 clk = ~clk;

  fpsc_top dut (.clk(clk), .reset(reset), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hf),
    .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack),
    .cfg_addr(cfg_addr), .cfg_data(cfg_data), .flash_blank(blank),
    .flash_read_block(read_block), .flash_erase_go(erase_go), .flash_write_go(write_go),
    .flash_op_addr(), .debug_full_enable(dbg_en), .cmd_irq(irq));

  fpsc_flash_model flash (.clk(clk), .cfg_addr(cfg_addr), .cfg_data(cfg_data),
    .erase_go(erase_go), .blank(blank));

  always @(posedge clk) if (write_go === 1'b1) wr_n <= wr_n + 1;
  always @(posedge clk) if (erase_go === 1'b1) er_n <= er_n + 1;

  task automatic complete_run;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Classic cycle: hold everything until ack is sampled high, then release
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 20) chk("bus ack", 32'h1, 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rc(input string name, input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(name, exp, q & m);
  endtask

  task automatic wait_done;
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      wb(1'b0, `FPSC_ADDR_STATUS, 32'h0, q);
      n++;
    end while (q[7] !== 1'b1 && n < 30);
    if (n >= 30) chk("complete flag", 32'h1, 32'h0);
  endtask

  // Clear any old violation first; it would otherwise mask a new one
  task automatic launch(input logic [7:0] code, input logic [15:0] a);
    wr(`FPSC_ADDR_STATUS, 32'h10);
    wr(`FPSC_ADDR_CMD, {8'h00, code, a});
    wr(`FPSC_ADDR_STATUS, 32'h80);
  endtask

  task automatic run(input logic [7:0] code, input logic [15:0] a);
    launch(code, a);
    wait_done();
  endtask

  task automatic rst;
    reset <= 1'b1;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    wait_done();
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    complete_run();
  end

  initial begin
    rst();
    rc("protection", `FPSC_ADDR_PROT, 32'hff, 32'ha0);
    rc("security", `FPSC_ADDR_SEC, 32'hff, 32'h80);
    rc("unmapped", 8'h20, 32'hffffffff, 32'h0);
    $display("test boot done");
    wr(`FPSC_ADDR_CONFIG, 32'h80);
    launch(8'h01, 16'h0000);
    repeat (2) @(posedge clk);
    chk("irq busy", 32'h0, {31'h0, irq});
    wait_done();
    repeat (2) @(posedge clk);
    chk("irq done", 32'h1, {31'h0, irq});
    wr(`FPSC_ADDR_CONFIG, 32'h0);
    repeat (2) @(posedge clk);
    chk("irq masked", 32'h0, {31'h0, irq});
    $display("test irq done");
    wr(`FPSC_ADDR_KEY01, 32'h12345678);
    wr(`FPSC_ADDR_KEY23, 32'h9abcdef0);
    launch(`FPSC_CMD_VERIFY_KEY, 16'h0000);
    repeat (2) @(posedge clk);
    chk("read block", 32'h1, {31'h0, read_block});
    rc("busy flag", `FPSC_ADDR_STATUS, 32'h80, 32'h0);
    wait_done();
    chk("read block", 32'h0, {31'h0, read_block});
    rc("key status", `FPSC_ADDR_STATUS, 32'h3, 32'h2);
    rc("security", `FPSC_ADDR_SEC, 32'hff, 32'h82);
    rc("protection", `FPSC_ADDR_PROT, 32'hff, 32'ha0);
    $display("test key match done");
    run(`FPSC_CMD_PROGRAM, `FPSC_CFG_SEC);
    chk("write pulses", 32'h1, wr_n);
    flash.mem[15] = 8'h81;
    rc("security", `FPSC_ADDR_SEC, 32'hff, 32'h82);
    run(`FPSC_CMD_ERASE_ALL, 16'h0000);
    chk("erase pulses", 32'h1, er_n);
    chk("debug enable", 32'h1, {31'h0, dbg_en});
    rc("debug reg", `FPSC_ADDR_DEBUG, 32'h1, 32'h1);
    $display("test erase done");
    wr(`FPSC_ADDR_PROT, 32'h80);
    rc("protection", `FPSC_ADDR_PROT, 32'hff, 32'h80);
    run(`FPSC_CMD_PROGRAM, 16'hf900);
    rc("violation", `FPSC_ADDR_STATUS, 32'h10, 32'h10);
    chk("write pulses", 32'h1, wr_n);
    run(`FPSC_CMD_PROGRAM, 16'h1000);
    rc("violation", `FPSC_ADDR_STATUS, 32'h10, 32'h0);
    chk("write pulses", 32'h2, wr_n);
    run(`FPSC_CMD_PROGRAM, 16'hc000);
    rc("violation", `FPSC_ADDR_STATUS, 32'h10, 32'h0);
    wr(`FPSC_ADDR_PROT, 32'h98);
    rc("protection", `FPSC_ADDR_PROT, 32'hff, 32'h98);
    run(`FPSC_CMD_PROGRAM, 16'hc000);
    rc("violation", `FPSC_ADDR_STATUS, 32'h10, 32'h10);
    run(`FPSC_CMD_ERASE_ALL, 16'h0000);
    rc("violation", `FPSC_ADDR_STATUS, 32'h10, 32'h10);
    for (int i = 0; i < 6; i++) begin
      wr(`FPSC_ADDR_PROT, {24'h0, pw[i]});
      rc("protection", `FPSC_ADDR_PROT, 32'hff, {24'h0, pe[i]});
    end
    run(`FPSC_CMD_PROGRAM, 16'h1000);
    rc("violation", `FPSC_ADDR_STATUS, 32'h10, 32'h10);
    $display("test protection done");
    flash.mem[0] = 8'h00;
    flash.mem[1] = 8'h00;
    rst();
    rc("protection", `FPSC_ADDR_PROT, 32'hff, 32'ha0);
    rc("security", `FPSC_ADDR_SEC, 32'hff, 32'h81);
    for (int i = 0; i < 2; i++) begin
      wr(`FPSC_ADDR_KEY01, 32'h00005678);
      wr(`FPSC_ADDR_KEY23, 32'h9abcdef0);
      run(`FPSC_CMD_VERIFY_KEY, 16'h0000);
      rc("key status", `FPSC_ADDR_STATUS, 32'h3, 32'h1);
      rc("security", `FPSC_ADDR_SEC, 32'hff, 32'h81);
    end
    $display("test key refusal done");
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
